// ===== verilog/dfs_pkg.sv
// Purpose: Shared constants and types of the driver fault supervisor.
// Assumes: System clock of 20 MHz.
// Notes:   Long counts except the watchdog reset pulse are defaults of top-level parameters.
package dfs_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;

    // Times as figures, then cycles at the system clock.
    localparam int unsigned OPEN_COIL_MS     = 200;
    localparam int unsigned OPEN_COIL_CYCLES = OPEN_COIL_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_UNIT_MS       = 32;
    localparam int unsigned WD_UNIT_CYCLES   = WD_UNIT_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_MIN_US        = 1000;
    localparam int unsigned WD_MIN_CYCLES    = WD_MIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PUMP_START_US    = 1000;
    localparam int unsigned PUMP_START_CYCLES = PUMP_START_US * (CLK_HZ / 1_000_000);
    localparam int unsigned POR_HOLD_US      = 1000;
    localparam int unsigned POR_HOLD_CYCLES  = POR_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WD_PULSE_US      = 100;
    localparam int unsigned WD_PULSE_CYCLES  = WD_PULSE_US * (CLK_HZ / 1_000_000);

    // Widths.
    localparam int CNT_W  = 24;
    localparam int CUR_W  = 5;
    localparam int BEMF_W = 8;
    localparam int SEL_W  = 4;

    // Register at 00h and its fields.
    localparam logic [4:0] REG_WD_CTRL_ADDR = 5'h00;
    localparam logic [7:0] WD_CTRL_RST      = 8'h00;
    localparam int         WD_ARM_BIT       = 7;
    localparam int         WD_SEL_LSB       = 0;

    // Status register selects and field positions.
    localparam logic [1:0] SR_ZERO = 2'h0;
    localparam logic [1:0] SR_ONE  = 2'h1;
    localparam logic [1:0] SR_TWO  = 2'h2;
    localparam int SR0_TW_BIT   = 0;
    localparam int SR0_PUMP_BIT = 1;
    localparam int SR0_OPEN_LSB = 2;
    localparam int SR0_BOOT_BIT = 4;
    localparam int SR_OVC_LSB   = 0;
    localparam int SR2_TSD_BIT  = 4;
    localparam int PARITY_BIT   = 7;

    // Positions in the synchroniser vector.
    localparam int SY_TW   = 0;
    localparam int SY_TSD  = 1;
    localparam int SY_DFX  = 2;
    localparam int SY_DFY  = 3;
    localparam int SY_PUMP = 4;
    localparam int SY_CS   = 5;
    localparam int SY_OVCX = 6;
    localparam int SY_OVCY = 10;
    localparam int SYNC_W  = 14;

    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_OFF  = 2'b01,
        ST_RUN  = 2'b10,
        ST_BITE = 2'b11
    } dfs_wd_state_e;
endpackage

// ===== verilog/dfs_watchdog.sv
// Purpose: Power-up reset hold and windowed watchdog driving the reset pin.
// Assumes: Kick strobes come from register writes on the same clock.
// Notes:   Reset pin is open drain; enable low means pulling low.
`timescale 1ns/1ps
module dfs_watchdog #(
    parameter int unsigned POR_CYC  = dfs_pkg::POR_HOLD_CYCLES,
    parameter int unsigned UNIT_CYC = dfs_pkg::WD_UNIT_CYCLES,
    parameter int unsigned MIN_CYC  = dfs_pkg::WD_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    // Register write of the control byte
    input  wire logic                    kick,
    input  wire logic                    arm,
    input  wire logic [dfs_pkg::SEL_W-1:0] period_sel,
    // Reset pin and event
    output logic                         reset_out_n_oe_n,
    output logic                         bite
);
    import dfs_pkg::*;

    dfs_wd_state_e      state_q, state_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d, limit;
    logic               expire;

    assign limit  = CNT_W'(UNIT_CYC) * (CNT_W'(period_sel) + 1'b1);
    assign expire = cnt_q >= limit - 1'b1;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 1'b1;
        case (state_q)
            ST_POR: begin
                if (cnt_q >= CNT_W'(POR_CYC - 1)) begin
                    state_d = ST_OFF;
                    cnt_d   = '0;
                end
            end
            ST_OFF: begin
                cnt_d = '0;
                if (kick && arm) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (kick && !arm) begin
                    state_d = ST_OFF;
                    cnt_d   = '0;
                end else if (kick && cnt_q < CNT_W'(MIN_CYC)) begin
                    state_d = ST_BITE;
                    cnt_d   = '0;
                end else if (kick) begin
                    cnt_d = '0;
                end else if (expire) begin
                    state_d = ST_BITE;
                    cnt_d   = '0;
                end
            end
            ST_BITE: begin
                // The controller reboots, so the watchdog comes back disarmed.
                if (cnt_q >= CNT_W'(WD_PULSE_CYCLES - 1)) begin
                    state_d = ST_OFF;
                    cnt_d   = '0;
                end
            end
            default: begin
                state_d = ST_OFF;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_POR;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_out_n_oe_n <= 1'b0;
            bite             <= 1'b0;
        end else begin
            reset_out_n_oe_n <= !(state_d == ST_POR || state_d == ST_BITE);
            bite             <= state_q == ST_RUN && state_d == ST_BITE;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_early;
        state_q == ST_RUN && kick && arm && cnt_q < CNT_W'(MIN_CYC);
    endsequence
    sequence s_late;
        state_q == ST_RUN && !kick && expire;
    endsequence

    a_por_hold: assert property (state_q == ST_POR |-> !reset_out_n_oe_n)
        else $error("reset pin released during power-up hold");
    a_wd_early: assert property (s_early |=> bite && !reset_out_n_oe_n)
        else $error("early kick did not reset the controller");
    a_wd_late: assert property (s_late |=> bite ##1 !reset_out_n_oe_n)
        else $error("watchdog expiry did not reset the controller");
    a_wd_restart: assert property (state_q == ST_RUN && kick && arm &&
        cnt_q >= CNT_W'(MIN_CYC) |=> state_q == ST_RUN && cnt_q == '0)
        else $error("timely kick did not restart the timer");
    a_wd_period: assert property (state_q == ST_RUN && !kick && !expire
        |=> state_q == ST_RUN && reset_out_n_oe_n)
        else $error("watchdog fired before its programmed interval");
endmodule

// ===== verilog/dfs_supervisor.sv
// Purpose: Fault latching, driver disable, back-emf output and reset supervision.
// Assumes: Serial framing is decoded elsewhere and arrives as one-cycle strobes.
// Notes:   Comparator inputs and chip select are asynchronous and synchronised here.
// Behaviour
// - New peak current setting takes effect at the next PWM period start.
// - Back-emf sampled at every coil zero crossing, four per electrical period.
// - Transparent mode follows coil voltage; otherwise hold the end-of-crossing sample.
// - Sampled voltage is divided by two or four per gain select.
// - Thermal warning flag set in status zero above warning threshold.
// - Thermal shutdown sets flag in status two and turns all drivers off.
// - Shutdown flag clears only below warning threshold and on status two read.
// - Over-current latches per-transistor flag and switches drivers off.
// - Drivers stay off until status one or two read clears the flags.
// - Full duty beyond 200 ms sets that coil's open-coil flag.
// - Open-coil timeout keeps the motor current flowing.
// - Pump failure flag set on low pump, held at one during start-up.
// - Fault output low while any warning or fault flag is set.
// - Fault output is open drain, only ever pulling low.
// - Reset output held low for a fixed time after power-up.
// - Writing the arm bit starts the watchdog; rewrites restart its timer.
// - Too early or missing refresh pulses the reset output.
// - Boot-cause bit tells a watchdog reset from a cold start.
// - Four-bit field in register 00h selects the watchdog interval.
// - Watchdog timeout is 32 ms times field value plus one.
// - Flags except boot cause, and fault output, change only while chip select is high; reads clear.
`timescale 1ns/1ps
module dfs_supervisor #(
    parameter int unsigned OPEN_CYC  = dfs_pkg::OPEN_COIL_CYCLES,
    parameter int unsigned PUMP_CYC  = dfs_pkg::PUMP_START_CYCLES,
    parameter int unsigned POR_CYC   = dfs_pkg::POR_HOLD_CYCLES,
    parameter int unsigned UNIT_CYC  = dfs_pkg::WD_UNIT_CYCLES,
    parameter int unsigned MIN_CYC   = dfs_pkg::WD_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         sys_rst,
    // Register access from the serial front end
    input  wire logic                         ctrl_wr_stb,
    input  wire logic [4:0]                   ctrl_wr_addr,
    input  wire logic [7:0]                   ctrl_wr_data,
    output logic      [7:0]                   watchdog_control,
    input  wire logic                         stat_rd_stb,
    input  wire logic [1:0]                   stat_rd_sel,
    output logic      [7:0]                   stat_rd_data,
    // Serial chip select pin
    input  wire logic                         spi_cs_n,
    // Current regulation and back-emf
    input  wire logic [dfs_pkg::CUR_W-1:0]    peak_current_setting,
    input  wire logic                         pwm_period_start,
    output logic      [dfs_pkg::CUR_W-1:0]    peak_current_applied,
    input  wire logic                         coil_x_zero,
    input  wire logic                         coil_y_zero,
    input  wire logic [dfs_pkg::BEMF_W-1:0]   coil_voltage,
    input  wire logic                         back_emf_transparent,
    input  wire logic                         back_emf_gain_select,
    output logic      [dfs_pkg::BEMF_W-1:0]   back_emf_output,
    // Analogue comparators
    input  wire logic                         temp_warn_cmp,
    input  wire logic                         temp_shut_cmp,
    input  wire logic [3:0]                   ovc_x_cmp,
    input  wire logic [3:0]                   ovc_y_cmp,
    input  wire logic                         duty_full_x,
    input  wire logic                         duty_full_y,
    input  wire logic                         pump_low_cmp,
    // Driver control and open-drain pins
    output logic                              drivers_off,
    output logic                              fault_output_n_o,
    output logic                              fault_output_n_oe_n,
    output logic                              reset_out_n_o,
    output logic                              reset_out_n_oe_n
);
    import dfs_pkg::*;

    logic [SYNC_W-1:0] sync1_q, sync_q, sync_raw;
    logic              cs_hi, tw_s, tsd_s, pump_s;
    logic [1:0]        full_s, open_ev, zero_q, zero_now;
    logic [3:0]        ovcx_s, ovcy_s;
    logic              tw_q, tsd_q, pump_q, boot_q, od_level_q;
    logic [1:0]        open_q;
    logic [3:0]        ovcx_q, ovcy_q;
    logic [2:0]        clr_pend_q;
    logic              clr0, clr1, clr2, any_flag, sample_ev, pump_busy;
    logic [CNT_W-1:0]  pump_cnt_q;
    logic [BEMF_W-1:0] held_q, bemf_src;
    logic [7:0]        sr_zero, sr_one, sr_two;
    logic              wd_bite, wd_kick;

    // Only the second stage is read; the first may be metastable.
    assign sync_raw = {ovc_y_cmp, ovc_x_cmp, spi_cs_n, pump_low_cmp,
                       duty_full_y, duty_full_x, temp_shut_cmp, temp_warn_cmp};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync_q  <= '0;
        end else begin
            sync1_q <= sync_raw;
            sync_q  <= sync1_q;
        end
    end

    assign cs_hi  = sync_q[SY_CS];
    assign tw_s   = sync_q[SY_TW];
    assign tsd_s  = sync_q[SY_TSD];
    assign pump_s = sync_q[SY_PUMP];
    assign full_s = sync_q[SY_DFY:SY_DFX];
    assign ovcx_s = sync_q[SY_OVCX+3:SY_OVCX];
    assign ovcy_s = sync_q[SY_OVCY+3:SY_OVCY];

    // Peak current only changes at a period boundary to avoid a torn PWM cycle.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            peak_current_applied <= '0;
        end else if (pwm_period_start) begin
            peak_current_applied <= peak_current_setting;
        end
    end

    // Back-emf sampling at the end of each zero-current window of either coil.
    assign zero_now  = {coil_y_zero, coil_x_zero};
    assign sample_ev = |(zero_q & ~zero_now);
    assign bemf_src  = back_emf_transparent ? coil_voltage : held_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_q          <= '0;
            held_q          <= '0;
            back_emf_output <= '0;
        end else begin
            zero_q <= zero_now;
            if (sample_ev) begin
                held_q <= coil_voltage;
            end
            back_emf_output <= back_emf_gain_select ? bemf_src >> 2 : bemf_src >> 1;
        end
    end

    // Full-duty timers, one per coil.
    for (genvar c = 0; c < 2; c++) begin : g_coil
        logic [CNT_W-1:0] cnt_q;
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cnt_q <= '0;
            end else if (!full_s[c]) begin
                cnt_q <= '0;
            end else if (cnt_q != CNT_W'(OPEN_CYC)) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        assign open_ev[c] = cnt_q == CNT_W'(OPEN_CYC);
    end

    // Pump start-up window after reset.
    assign pump_busy = pump_cnt_q != '0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pump_cnt_q <= CNT_W'(PUMP_CYC);
        end else if (pump_busy) begin
            pump_cnt_q <= pump_cnt_q - 1'b1;
        end
    end

    // Read clears wait for chip select high, as the flags do.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_pend_q <= '0;
        end else begin
            if (cs_hi) begin
                clr_pend_q <= '0;
            end
            if (stat_rd_stb && stat_rd_sel != 2'h3) begin
                clr_pend_q[stat_rd_sel] <= 1'b1;
            end
        end
    end

    assign clr0 = clr_pend_q[0] & cs_hi;
    assign clr1 = clr_pend_q[1] & cs_hi;
    assign clr2 = clr_pend_q[2] & cs_hi;

    // A set in the cycle of a clear wins, so no event is lost.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tw_q   <= 1'b0;
            tsd_q  <= 1'b0;
            ovcx_q <= '0;
            ovcy_q <= '0;
            open_q <= '0;
            pump_q <= 1'b1;
        end else if (cs_hi) begin
            tw_q   <= tw_s | (tw_q & ~clr0);
            tsd_q  <= tsd_s | (tsd_q & ~(clr2 & ~tw_s));
            ovcx_q <= ovcx_s | (ovcx_q & ~{4{clr1}});
            ovcy_q <= ovcy_s | (ovcy_q & ~{4{clr2}});
            open_q <= open_ev | (open_q & ~{2{clr0}});
            pump_q <= pump_s | pump_busy | (pump_q & ~clr0);
        end
    end

    // Boot cause is set at once so a bite during a transfer is not missed.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= wd_bite | (boot_q & ~clr0);
        end
    end

    // Open-coil flags do not disable drivers, so current keeps flowing.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            drivers_off <= 1'b0;
        end else begin
            drivers_off <= tsd_q | (|ovcx_q) | (|ovcy_q);
        end
    end

    assign any_flag = tw_q | tsd_q | (|ovcx_q) | (|ovcy_q) | (|open_q) | pump_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_output_n_oe_n <= 1'b0;
            od_level_q          <= 1'b0;
        end else begin
            od_level_q <= 1'b0;
            if (cs_hi) begin
                fault_output_n_oe_n <= ~any_flag;
            end
        end
    end

    assign fault_output_n_o = od_level_q;
    assign reset_out_n_o    = od_level_q;

    // Status images with parity in the top bit.
    function automatic logic [7:0] with_parity(input logic [7:0] v);
        logic [7:0] r;
        r             = v;
        r[PARITY_BIT] = ^v[6:0];
        return r;
    endfunction

    always_comb begin
        sr_zero                                = '0;
        sr_zero[SR0_TW_BIT]                    = tw_q;
        sr_zero[SR0_PUMP_BIT]                  = pump_q;
        sr_zero[SR0_OPEN_LSB+1:SR0_OPEN_LSB]   = open_q;
        sr_zero[SR0_BOOT_BIT]                  = boot_q;
        sr_one                                 = '0;
        sr_one[SR_OVC_LSB+3:SR_OVC_LSB]        = ovcx_q;
        sr_two                                 = '0;
        sr_two[SR_OVC_LSB+3:SR_OVC_LSB]        = ovcy_q;
        sr_two[SR2_TSD_BIT]                    = tsd_q;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_rd_data <= '0;
        end else if (stat_rd_stb) begin
            case (stat_rd_sel)
                SR_ZERO: stat_rd_data <= with_parity(sr_zero);
                SR_ONE:  stat_rd_data <= with_parity(sr_one);
                SR_TWO:  stat_rd_data <= with_parity(sr_two);
                default: stat_rd_data <= '0;
            endcase
        end
    end

    // Control register 00h.
    assign wd_kick = ctrl_wr_stb && ctrl_wr_addr == REG_WD_CTRL_ADDR;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_control <= WD_CTRL_RST;
        end else if (wd_kick) begin
            watchdog_control <= ctrl_wr_data;
        end
    end

    dfs_watchdog #(
        .POR_CYC  (POR_CYC),
        .UNIT_CYC (UNIT_CYC),
        .MIN_CYC  (MIN_CYC)
    ) u_wd (
        .sys_clk          (sys_clk),
        .sys_rst          (sys_rst),
        .kick             (wd_kick),
        .arm              (ctrl_wr_data[WD_ARM_BIT]),
        .period_sel       (watchdog_control[WD_SEL_LSB+SEL_W-1:WD_SEL_LSB]),
        .reset_out_n_oe_n (reset_out_n_oe_n),
        .bite             (wd_bite)
    );

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_sr0_read;
        stat_rd_stb && stat_rd_sel == SR_ZERO && !tw_s ##1 cs_hi && !tw_s;
    endsequence

    a_peak_hold: assert property (!pwm_period_start |=> $stable(peak_current_applied))
        else $error("peak current changed inside a PWM period");
    a_peak_take: assert property (pwm_period_start
        |=> peak_current_applied == $past(peak_current_setting))
        else $error("peak current not taken at period start");
    a_bemf_sample: assert property (sample_ev |=> held_q == $past(coil_voltage))
        else $error("back-emf not sampled at zero crossing end");
    a_bemf_hold: assert property (!sample_ev |=> $stable(held_q))
        else $error("held back-emf sample changed between crossings");
    a_bemf_scale: assert property (back_emf_transparent && back_emf_gain_select
        |=> back_emf_output == $past(coil_voltage) >> 2)
        else $error("back-emf output not divided by four");
    a_tw_set: assert property (cs_hi && tw_s |=> tw_q)
        else $error("thermal warning not latched");
    a_tsd_drv: assert property (cs_hi && tsd_s |=> tsd_q ##1 drivers_off)
        else $error("thermal shutdown did not disable drivers");
    a_tsd_keep: assert property (tsd_q && tw_s |=> tsd_q)
        else $error("shutdown flag cleared while still hot");
    a_ovc_drv: assert property (cs_hi && (|ovcx_s) |=> (|ovcx_q) ##1 drivers_off)
        else $error("over-current did not latch and disable drivers");
    a_ovc_keep: assert property ((|ovcy_q) && !clr2 |=> (|ovcy_q))
        else $error("over-current flag cleared without a read");
    a_open_flag: assert property (cs_hi && open_ev[0] |=> open_q[0])
        else $error("open-coil flag not set after timeout");
    a_open_alive: assert property ((|open_q) && !tsd_q && ovcx_q == '0
        && ovcy_q == '0 |=> !drivers_off)
        else $error("open-coil timeout cut the motor current");
    a_pump_start: assert property (pump_busy |-> pump_q)
        else $error("pump flag low during start-up");
    a_fault_low: assert property (cs_hi && any_flag |=> !fault_output_n_oe_n)
        else $error("fault output not pulled low");
    a_fault_od: assert property (fault_output_n_o == 1'b0)
        else $error("fault pin drives high");
    a_boot_set: assert property (wd_bite |=> boot_q)
        else $error("boot cause not recorded");
    a_frozen: assert property (!cs_hi |=> $stable({tw_q, tsd_q, ovcx_q, ovcy_q, open_q})
        && $stable(fault_output_n_oe_n))
        else $error("status changed while chip select low");
    a_read_clr: assert property (s_sr0_read |=> !tw_q)
        else $error("status zero not cleared after read");
endmodule

// ===== verif/dfs_mcu_model.sv
// Purpose: Controller end of the open-drain pins.
// Assumes: Pull-ups on both lines.
// Notes:   A released line reads high, never the last driven level.
`timescale 1ns/1ps
module dfs_mcu_model (
    // Device pin drive levels and enables
    input  wire logic fault_output_n_o,
    input  wire logic fault_output_n_oe_n,
    input  wire logic reset_out_n_o,
    input  wire logic reset_out_n_oe_n,
    // Levels the controller sees through its pull-ups
    output logic      fault_line,
    output logic      reset_line
);
    // While enabled the line shows what the device drives, so a high drive would show up.
    assign fault_line = fault_output_n_oe_n ? 1'b1 : fault_output_n_o;
    assign reset_line = reset_out_n_oe_n ? 1'b1 : reset_out_n_o;
endmodule

// ===== verif/tb.sv
// Purpose: Bench for the fault supervisor.
// Assumes: Short counts set by parameter.
// Notes:   Every wait is a fixed count.
`timescale 1ns/1ps
module tb;
    import dfs_pkg::*;
    logic sys_clk = 0, sys_rst = 1, ctrl_wr_stb = 0, stat_rd_stb = 0, spi_cs_n = 1;
    logic pwm_period_start = 0, coil_x_zero = 0, coil_y_zero = 0, back_emf_transparent = 1;
    logic back_emf_gain_select = 0, temp_warn_cmp = 0, temp_shut_cmp = 0, pump_low_cmp = 0;
    logic duty_full_x = 0, duty_full_y = 0, drivers_off, fault_line, reset_line;
    logic fault_output_n_oe_n, reset_out_n_oe_n, fault_output_n_o, reset_out_n_o;
    logic [7:0] ctrl_wr_data = 0, coil_voltage = 0, watchdog_control, stat_rd_data;
    logic [7:0] back_emf_output;
    logic [4:0] ctrl_wr_addr = 0, peak_current_setting = 0, peak_current_applied;
    logic [3:0] ovc_x_cmp = 0, ovc_y_cmp = 0;
    logic [1:0] stat_rd_sel = 0;
    int error_cnt = 0, n_tests = 0;
    always #25 sys_clk = ~sys_clk;
    dfs_supervisor #(.OPEN_CYC(50), .PUMP_CYC(10), .POR_CYC(8), .UNIT_CYC(40), .MIN_CYC(5))
        i_dut (.sys_clk, .sys_rst, .ctrl_wr_stb, .ctrl_wr_addr, .ctrl_wr_data,
            .watchdog_control, .stat_rd_stb, .stat_rd_sel, .stat_rd_data, .spi_cs_n,
            .peak_current_setting, .pwm_period_start, .peak_current_applied, .coil_x_zero,
            .coil_y_zero, .coil_voltage, .back_emf_transparent, .back_emf_gain_select,
            .back_emf_output, .temp_warn_cmp, .temp_shut_cmp, .ovc_x_cmp, .ovc_y_cmp,
            .duty_full_x, .duty_full_y, .pump_low_cmp, .drivers_off, .fault_output_n_o,
            .fault_output_n_oe_n, .reset_out_n_o, .reset_out_n_oe_n);
    dfs_mcu_model i_mcu (.fault_output_n_o, .fault_output_n_oe_n, .reset_out_n_o,
        .reset_out_n_oe_n, .fault_line, .reset_line);
    task cyc(input int n); repeat (n) @(posedge sys_clk); #1; endtask
    task chk(input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin error_cnt++; $display("Error %0t: got %h want %h", $time, s, e); end
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        stat_rd_sel = a; stat_rd_stb = 1; cyc(1); stat_rd_stb = 0; cyc(4); chk(stat_rd_data, e);
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        ctrl_wr_addr = a; ctrl_wr_data = d; ctrl_wr_stb = 1; cyc(1); ctrl_wr_stb = 0;
    endtask
    task test_done;
        $display("Checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin #1_000_000 error_cnt++; test_done; end
    task t_por;
        cyc(4); chk(reset_line, 0); chk(fault_line, 0);
        cyc(10); chk(reset_line, 1); rd(SR_ZERO, 8'h82);
        chk(fault_line, 1); $display("power-up done");
    endtask
    task t_out;
        peak_current_setting = 5'h13; coil_voltage = 8'hc8; back_emf_gain_select = 1; cyc(2);
        chk(peak_current_applied, 5'h00);
        pwm_period_start = 1; cyc(1); pwm_period_start = 0; cyc(2);
        chk(peak_current_applied, 5'h13); chk(back_emf_output, 8'h32);
        back_emf_transparent = 0; back_emf_gain_select = 0; coil_x_zero = 1; cyc(2);
        coil_voltage = 8'h64; coil_x_zero = 0; cyc(1); coil_voltage = 8'h10; cyc(2);
        chk(back_emf_output, 8'h32);
        $display("outputs done");
    endtask
    // Comparator inputs other than temp_shut_cmp drop three edges before a read, so the clear is not overridden.
    task t_flt;
        temp_warn_cmp = 1; temp_shut_cmp = 1; cyc(6); chk(drivers_off, 1);
        temp_shut_cmp = 0; rd(SR_TWO, 8'h90); temp_warn_cmp = 0; cyc(3);
        rd(SR_ZERO, 8'h81); rd(SR_TWO, 8'h90); rd(SR_TWO, 8'h00);
        spi_cs_n = 0; cyc(3); ovc_x_cmp = 4'h4; ovc_y_cmp = 4'h1; cyc(6);
        chk(drivers_off, 0); chk(fault_line, 1); spi_cs_n = 1; cyc(6);
        ovc_x_cmp = 0; ovc_y_cmp = 0; cyc(3); rd(SR_ONE, 8'h84); chk(drivers_off, 1);
        rd(SR_TWO, 8'h81); chk(drivers_off, 0); $display("faults done");
    endtask
    task t_open;
        pump_low_cmp = 1; cyc(5); chk(fault_line, 0); pump_low_cmp = 0; cyc(3);
        rd(SR_ZERO, 8'h82); duty_full_x = 1; cyc(60); chk(drivers_off, 0);
        chk(fault_line, 0); duty_full_x = 0; cyc(3); rd(SR_ZERO, 8'h84);
        chk(fault_line, 1); $display("open coil done");
    endtask
    task t_wd;
        wr(5'h01, 8'h8f); chk(watchdog_control, 8'h00); cyc(1);
        wr(5'h00, 8'h80); cyc(20); wr(5'h00, 8'h80); cyc(30); chk(reset_line, 1);
        cyc(15); chk(reset_line, 0); cyc(2010); chk(reset_line, 1);
        rd(SR_ZERO, 8'h90); wr(5'h00, 8'h81); cyc(1); wr(5'h00, 8'h81);
        cyc(3); chk(reset_line, 0); chk(watchdog_control, 8'h81);
        $display("watchdog done");
    endtask
    initial begin cyc(20); sys_rst = 0; t_por; t_out; t_flt; t_open; t_wd; test_done; end
endmodule
